// ### rtl/bsr_basic_status.sv
// Basic mode status register with preamble skip tracking
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// RULE1: Bit 15, four-pair 100 Mb ability, always reads zero.
// RULE2: Bits 14 to 11 read one: 100 and 10 Mb, full and half duplex.
// RULE3: Preamble needed once after reset or bad frame; later frames may skip it.
// RULE4: Master waits 500 ns, then one clock edge with data high, before next frame.
// RULE5: Bit 6 reads one: preamble skip ability.
// RULE6: Bit 5 reads one only when negotiation finished, else zero.
// RULE7: Bit 4 latches remote fault; cleared by read or reset.
// RULE8: Bit 3 reads one: auto-negotiation ability.
// RULE9: Bit 2 latches link loss; a read returns state since previous read.
// RULE10: Bit 1 latches jabber, only counted during 10 Mb operation.
// RULE11: Bit 0 reads one: extended registers present.
// RULE12: Register sits at management address 1 and reads 7849h after reset.
// RULE13: Reserved bits 10 to 7 read zero; writes are ignored.
module bsr_basic_status (
  input  wire logic              clk_i,
  input  wire logic              reset_i,
  input  wire logic [4:0]        mgmt_addr_i,
  input  wire logic              mgmt_rd_i,
  input  wire logic              mgmt_wr_i,
  input  wire logic [15:0]       mgmt_wdata_i,
  output logic      [15:0]       mgmt_rdata_o,
  output logic                   mgmt_rvalid_o,
  input  wire logic              link_i,
  input  wire logic              remote_fault_i,
  input  wire logic              jabber_i,
  input  wire logic              speed_10_i,
  input  wire logic              an_enable_i,
  input  wire logic              an_complete_i,
  input  wire logic              an_restart_i,
  input  wire logic              mdc_i,
  input  wire logic              mdio_i,
  input  wire logic              frame_err_i,
  input  wire logic              frame_end_i,
  output logic                   preamble_needed_o,
  output logic                   frame_start_ok_o
);
  import bsr_pkg::*;

  function automatic logic bsr_hit(input logic [4:0] addr);
    bsr_hit = (addr == BSR_REG_ADDR); // [RULE12]
  endfunction

  bsr_evt_if evt ();

  logic                     rd_hit;
  logic [15:0]              word;
  logic [15:0]              rdata_r;
  logic                     rvalid_r;
  logic                     link_latch_r;
  logic                     mdc_q_r;
  logic                     mdc_rise;
  logic [BSR_PRE_CNT_W-1:0] ones_cnt_r;
  bsr_pre_e                 pre_state_r;
  logic [BSR_GAP_CNT_W-1:0] gap_cnt_r;
  logic                     gap_met;
  logic                     idle_edge_r;

  ////////////////////////////////////////////////////////////////////////////
  // Read decode; the write strobe has no path into this register
  assign rd_hit = mgmt_rd_i && bsr_hit(mgmt_addr_i); // [RULE13]

  assign evt.set[BSR_EVT_RF]  = remote_fault_i; // [RULE7]
  // Jabber is meaningless at 100 Mb, so it is masked there
  assign evt.set[BSR_EVT_JAB] = jabber_i && speed_10_i; // [RULE10]
  assign evt.clr              = rd_hit;

  bsr_evt_latch u_evt_latch (
    .clk_i   (clk_i),
    .reset_i (reset_i),
    .evt     (evt)
  );

  always_comb begin
    word                             = 16'h0000; // [RULE13]
    word[BSR_BIT_T4]                 = 1'b0; // [RULE1]
    word[BSR_BIT_TX_FD]              = 1'b1; // [RULE2]
    word[BSR_BIT_TX_HD]              = 1'b1; // [RULE2]
    word[BSR_BIT_10_FD]              = 1'b1; // [RULE2]
    word[BSR_BIT_10_HD]              = 1'b1; // [RULE2]
    word[BSR_BIT_PRE]                = 1'b1; // [RULE5]
    word[BSR_BIT_ANC]                = an_enable_i && an_complete_i && !an_restart_i; // [RULE6]
    word[BSR_BIT_RF]                 = evt.q[BSR_EVT_RF];
    word[BSR_BIT_ANA]                = 1'b1; // [RULE8]
    word[BSR_BIT_LINK]               = link_latch_r; // [RULE9]
    word[BSR_BIT_JAB]                = evt.q[BSR_EVT_JAB];
    word[BSR_BIT_EXT]                = 1'b1; // [RULE11]
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link latch: a drop sticks until read, a read reloads the live state
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      link_latch_r <= 1'b0;
    end else if (rd_hit) begin
      link_latch_r <= link_i; // [RULE9]
    end else if (!link_i) begin
      link_latch_r <= 1'b0; // [RULE9]
    end
  end

  // Read data; unmapped addresses return zero
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rdata_r <= 16'h0000;
    end else if (mgmt_rd_i) begin
      rdata_r <= rd_hit ? word : 16'h0000; // [RULE12]
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      rvalid_r <= 1'b0;
    end else begin
      rvalid_r <= mgmt_rd_i;
    end
  end

  assign mgmt_rdata_o  = rdata_r;
  assign mgmt_rvalid_o = rvalid_r;

  ////////////////////////////////////////////////////////////////////////////
  // Preamble tracking on sampled management clock edges
  assign mdc_rise = mdc_i && !mdc_q_r;

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      mdc_q_r <= 1'b0;
    end else begin
      mdc_q_r <= mdc_i;
    end
  end

  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      ones_cnt_r <= '0;
    end else if (frame_err_i) begin
      ones_cnt_r <= '0; // [RULE3]
    end else if (mdc_rise) begin
      if (!mdio_i) begin
        ones_cnt_r <= '0;
      end else if (ones_cnt_r != BSR_PREAMBLE_BITS) begin
        ones_cnt_r <= ones_cnt_r + 6'h01;
      end
    end
  end

  // Once a full preamble is seen, later frames may leave it out
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      pre_state_r <= BSR_PRE_HUNT;
    end else begin
      unique case (pre_state_r)
        BSR_PRE_HUNT: begin
          if (!frame_err_i && mdc_rise && mdio_i &&
              ones_cnt_r == BSR_PREAMBLE_BITS - 6'h01) begin
            pre_state_r <= BSR_PRE_SKIP; // [RULE3]
          end
        end
        BSR_PRE_SKIP: begin
          if (frame_err_i) begin
            pre_state_r <= BSR_PRE_HUNT; // [RULE3]
          end
        end
      endcase
    end
  end

  assign preamble_needed_o = (pre_state_r == BSR_PRE_HUNT);

  ////////////////////////////////////////////////////////////////////////////
  // Gap timer; starts full so the first frame after reset is not held off
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      gap_cnt_r <= BSR_GAP_CYCLES;
    end else if (frame_end_i) begin
      gap_cnt_r <= '0; // [RULE4]
    end else if (gap_cnt_r != BSR_GAP_CYCLES) begin
      gap_cnt_r <= gap_cnt_r + 6'h01;
    end
  end

  assign gap_met = (gap_cnt_r == BSR_GAP_CYCLES);

  // An idle edge only counts once the gap has elapsed
  always_ff @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      idle_edge_r <= 1'b0;
    end else if (frame_end_i || frame_err_i) begin
      idle_edge_r <= 1'b0;
    end else if (mdc_rise && mdio_i && gap_met) begin
      idle_edge_r <= 1'b1; // [RULE4]
    end
  end

  assign frame_start_ok_o = (pre_state_r == BSR_PRE_SKIP) && idle_edge_r; // [RULE3]

  ////////////////////////////////////////////////////////////////////////////
  property p_t4_zero;
    @(posedge clk_i) disable iff (reset_i)
    rd_hit |=> !mgmt_rdata_o[BSR_BIT_T4];
  endproperty
  a_t4_zero: assert property (p_t4_zero) else $error("T4 bit set"); // [RULE1]

  property p_abilities;
    @(posedge clk_i) disable iff (reset_i)
    rd_hit |=> mgmt_rdata_o[BSR_BIT_TX_FD:BSR_BIT_10_HD] == 4'hf;
  endproperty
  a_abilities: assert property (p_abilities) else $error("speed bits wrong"); // [RULE2]

  property p_pre_err;
    @(posedge clk_i) disable iff (reset_i)
    frame_err_i |=> preamble_needed_o [*8];
  endproperty
  a_pre_err: assert property (p_pre_err) else $error("preamble skip kept"); // [RULE3]

  property p_gap;
    @(posedge clk_i) disable iff (reset_i)
    frame_end_i |=> !frame_start_ok_o [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("start allowed in gap"); // [RULE4]

  property p_fixed_ones;
    @(posedge clk_i) disable iff (reset_i)
    rd_hit |=> mgmt_rvalid_o && mgmt_rdata_o[BSR_BIT_PRE] &&
               mgmt_rdata_o[BSR_BIT_ANA] && mgmt_rdata_o[BSR_BIT_EXT];
  endproperty
  a_fixed_ones: assert property (p_fixed_ones) else $error("fixed bit low"); // [RULE5] [RULE8] [RULE11]

  property p_anc;
    @(posedge clk_i) disable iff (reset_i)
    (rd_hit && (!an_enable_i || an_restart_i)) |=> !mgmt_rdata_o[BSR_BIT_ANC];
  endproperty
  a_anc: assert property (p_anc) else $error("AN complete too early"); // [RULE6]

  property p_rf;
    @(posedge clk_i) disable iff (reset_i)
    remote_fault_i ##1 rd_hit |=> mgmt_rdata_o[BSR_BIT_RF];
  endproperty
  a_rf: assert property (p_rf) else $error("remote fault lost"); // [RULE7]

  property p_link;
    @(posedge clk_i) disable iff (reset_i)
    (!link_i && !rd_hit) ##1 rd_hit |=> !mgmt_rdata_o[BSR_BIT_LINK];
  endproperty
  a_link: assert property (p_link) else $error("link drop not latched"); // [RULE9]

  property p_jab;
    @(posedge clk_i) disable iff (reset_i)
    (jabber_i && speed_10_i) ##1 rd_hit |=> mgmt_rdata_o[BSR_BIT_JAB];
  endproperty
  a_jab: assert property (p_jab) else $error("jabber lost"); // [RULE10]

  property p_unmapped;
    @(posedge clk_i) disable iff (reset_i)
    (mgmt_rd_i && !bsr_hit(mgmt_addr_i)) |=> mgmt_rdata_o == 16'h0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read data"); // [RULE12]

  property p_reset_read;
    @(posedge clk_i) disable iff (reset_i)
    ($past(reset_i) && rd_hit && !link_i && !an_complete_i && !remote_fault_i &&
     !jabber_i) |=> mgmt_rdata_o == BSR_RESET_VAL;
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("reset value wrong"); // [RULE12]

  property p_wr_ignored;
    @(posedge clk_i) disable iff (reset_i)
    (mgmt_wr_i && bsr_hit(mgmt_addr_i) && !mgmt_rd_i && mgmt_wdata_i != 16'h0000)
      |=> $stable(mgmt_rdata_o);
  endproperty
  a_wr_ignored: assert property (p_wr_ignored) else $error("write took effect"); // [RULE13]

  property p_reserved;
    @(posedge clk_i) disable iff (reset_i)
    mgmt_rvalid_o |-> mgmt_rdata_o[BSR_RSV_HI:BSR_RSV_LO] == 4'h0;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits set"); // [RULE13]

endmodule
`default_nettype wire

// ### rtl/bsr_evt_if.sv
// Interface between the status register and its sticky event latches
`timescale 1ns/10ps
`default_nettype none
interface bsr_evt_if;
  logic [bsr_pkg::BSR_N_EVT-1:0] set;
  logic                          clr;
  logic [bsr_pkg::BSR_N_EVT-1:0] q;

  modport owner (output set, output clr, input q);
  modport latch (input set, input clr, output q);
endinterface
`default_nettype wire

// ### rtl/bsr_evt_latch.sv
// Sticky event latches that clear on a register read
`timescale 1ns/10ps
`default_nettype none
module bsr_evt_latch (
  input  wire logic clk_i,
  input  wire logic reset_i,
  bsr_evt_if.latch  evt
);
  import bsr_pkg::*;

  logic [BSR_N_EVT-1:0] q_r;

  assign evt.q = q_r;

  ////////////////////////////////////////////////////////////////////////////
  genvar g;
  generate
    for (g = 0; g < BSR_N_EVT; g++) begin : g_evt
      // An event in the reading cycle survives into the next read
      always_ff @(posedge clk_i or posedge reset_i) begin
        if (reset_i) begin
          q_r[g] <= 1'b0;
        end else if (evt.set[g]) begin
          q_r[g] <= 1'b1; // [RULE7] [RULE10]
        end else if (evt.clr) begin
          q_r[g] <= 1'b0; // [RULE7]
        end
      end

      property p_set_wins;
        @(posedge clk_i) disable iff (reset_i)
        evt.set[g] |=> q_r[g];
      endproperty
      a_set_wins: assert property (p_set_wins) else $error("event lost"); // [RULE7]

      property p_clr_read;
        @(posedge clk_i) disable iff (reset_i)
        (evt.clr && !evt.set[g]) |=> !q_r[g];
      endproperty
      a_clr_read: assert property (p_clr_read) else $error("latch not cleared"); // [RULE7]
    end
  endgenerate

endmodule
`default_nettype wire

// ### rtl/bsr_pkg.sv
// Constants and types shared by the basic mode status register block
`default_nettype none
package bsr_pkg;

  // Management address and value seen by the first read after reset
  localparam logic [4:0]  BSR_REG_ADDR  = 5'h01;
  localparam logic [15:0] BSR_RESET_VAL = 16'h7849;

  // Field positions of basic_mode_status
  localparam int BSR_BIT_T4    = 15;
  localparam int BSR_BIT_TX_FD = 14;
  localparam int BSR_BIT_TX_HD = 13;
  localparam int BSR_BIT_10_FD = 12;
  localparam int BSR_BIT_10_HD = 11;
  localparam int BSR_RSV_HI    = 10;
  localparam int BSR_RSV_LO    = 7;
  localparam int BSR_BIT_PRE   = 6;
  localparam int BSR_BIT_ANC   = 5;
  localparam int BSR_BIT_RF    = 4;
  localparam int BSR_BIT_ANA   = 3;
  localparam int BSR_BIT_LINK  = 2;
  localparam int BSR_BIT_JAB   = 1;
  localparam int BSR_BIT_EXT   = 0;

  // Sticky event latches, index into the latch vector
  localparam int BSR_N_EVT   = 2;
  localparam int BSR_EVT_RF  = 0;
  localparam int BSR_EVT_JAB = 1;

  // Preamble tracking
  localparam int             BSR_PRE_CNT_W     = 6;
  localparam logic [5:0]     BSR_PREAMBLE_BITS = 6'h20;

  // Inter-frame gap when the preamble is left out
  localparam int         BSR_CLK_NS     = 10;
  localparam int         BSR_GAP_NS     = 500;
  localparam int         BSR_GAP_CNT_W  = 6;
  localparam logic [5:0] BSR_GAP_CYCLES =
    6'((BSR_GAP_NS + BSR_CLK_NS - 1) / BSR_CLK_NS);

  typedef enum logic {
    BSR_PRE_HUNT = 1'b0,
    BSR_PRE_SKIP = 1'b1
  } bsr_pre_e;

endpackage
`default_nettype wire

// ### test/bsr_mgmt_model.sv
// Station management controller model driving management clock and data
`timescale 1ns/10ps
`default_nettype none
module bsr_mgmt_model (
  input  wire logic clk_i,
  output logic      mdc_o,
  output logic      mdio_o,
  output logic      frame_end_o,
  output logic      frame_err_o
);
  // Clock stands low between frames; released data floats high on its pull-up
  initial begin
    mdc_o = 1'b0;
    mdio_o = 1'b1;
    frame_end_o = 1'b0;
    frame_err_o = 1'b0;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic bit_out(input logic d);
    mdio_o <= d;
    @(posedge clk_i);
    mdc_o <= 1'b1;
    @(posedge clk_i);
    mdc_o <= 1'b0;
  endtask
  // Full preamble only after reset or a refused frame
  task automatic preamble(input int n);
    repeat (n) bit_out(1'b1);
  endtask
  task automatic frame(input logic [15:0] bits);
    for (int i = 15; i >= 0; i--) bit_out(bits[i]);
    // Data released once per frame so no bit sees two drives in one step
    mdio_o <= 1'b1;
    frame_end_o <= 1'b1;
    @(posedge clk_i);
    frame_end_o <= 1'b0;
  endtask
  // Gap, then one rise with data high before a frame without preamble
  task automatic gap_rise(input int cycles);
    repeat (cycles) @(posedge clk_i);
    bit_out(1'b1);
  endtask
  task automatic bad_frame();
    frame_err_o <= 1'b1;
    @(posedge clk_i);
    frame_err_o <= 1'b0;
  endtask
endmodule
`default_nettype wire

// ### test/phy_basic_status_register_test.sv
// Self-checking bench for the basic mode status register
`timescale 1ns/10ps
`default_nettype none
module phy_basic_status_register_test;
  import bsr_pkg::*;
  logic        clk_i, reset_i, rd, wr, link, rf, jab, s10, an_en, an_cp, an_rs;
  logic        rvalid, mdc, mdio, fend, ferr, pneed, sok, lnk_l, rf_l, jab_l, exp_v, hit;
  logic [4:0]  addr;
  logic [15:0] wdata, rdata, exp_d, w;
  int          error_cnt = 0;
  int          n_checks = 0;
  int          seed = 34;
  localparam logic [15:0] CAP = (16'h1 << BSR_BIT_TX_FD) | (16'h1 << BSR_BIT_TX_HD) |
    (16'h1 << BSR_BIT_10_FD) | (16'h1 << BSR_BIT_10_HD) | (16'h1 << BSR_BIT_PRE) |
    (16'h1 << BSR_BIT_ANA) | (16'h1 << BSR_BIT_EXT);

  bsr_basic_status bsr_basic_status_inst (.clk_i(clk_i), .reset_i(reset_i),
    .mgmt_addr_i(addr), .mgmt_rd_i(rd), .mgmt_wr_i(wr), .mgmt_wdata_i(wdata),
    .mgmt_rdata_o(rdata), .mgmt_rvalid_o(rvalid), .link_i(link), .remote_fault_i(rf),
    .jabber_i(jab), .speed_10_i(s10), .an_enable_i(an_en), .an_complete_i(an_cp),
    .an_restart_i(an_rs), .mdc_i(mdc), .mdio_i(mdio), .frame_err_i(ferr),
    .frame_end_i(fend), .preamble_needed_o(pneed), .frame_start_ok_o(sok));
  bsr_mgmt_model bsr_mgmt_model_inst (.clk_i(clk_i), .mdc_o(mdc), .mdio_o(mdio),
    .frame_end_o(fend), .frame_err_o(ferr));
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Checks read the settled values of the previous cycle; stimulus lands on the edge
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  // Reference model: answer one cycle after each read, sticky bits updated per cycle
  always @(posedge clk_i or posedge reset_i) begin
    if (reset_i) begin
      lnk_l <= 1'b0;
      rf_l <= 1'b0;
      jab_l <= 1'b0;
      exp_v <= 1'b0;
    end else begin
      chk(16'(rvalid), 16'(exp_v), "rvalid");
      if (exp_v) chk(rdata, exp_d, "rdata");
      hit = rd && addr == BSR_REG_ADDR;
      w = CAP;
      w[BSR_BIT_ANC] = an_en & an_cp & ~an_rs;
      w[BSR_BIT_RF] = rf_l;
      w[BSR_BIT_LINK] = lnk_l;
      w[BSR_BIT_JAB] = jab_l;
      exp_v <= rd;
      exp_d <= hit ? w : 16'h0000;
      lnk_l <= hit ? link : lnk_l & link;
      rf_l <= (hit ? 1'b0 : rf_l) | rf;
      jab_l <= (hit ? 1'b0 : jab_l) | (jab & s10);
    end
  end
  // Random status and register traffic, back-to-back reads and writes included
  task automatic traffic(input int n);
    repeat (n) begin
      @(posedge clk_i);
      rd <= 1'($random(seed));
      addr <= (($random(seed) & 3) == 0) ? 5'($random(seed)) : BSR_REG_ADDR;
      wr <= 1'($random(seed));
      wdata <= 16'($random(seed));
      link <= (($random(seed) & 7) != 0);
      rf <= (($random(seed) & 15) == 0);
      jab <= (($random(seed) & 15) == 0);
      s10 <= 1'($random(seed));
      an_en <= 1'($random(seed));
      an_cp <= 1'($random(seed));
      an_rs <= (($random(seed) & 3) == 0);
    end
    @(posedge clk_i);
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  initial begin
    #100us;
    error_cnt++;
    $display("unexpected at %0t: timeout", $time);
    complete_run();
  end
  initial begin
    {reset_i, rd, wr, link, rf, jab, s10, an_en, an_cp, an_rs} = 10'h200;
    addr = BSR_REG_ADDR;
    wdata = 16'h0000;
    tick(8);
    chk(16'(pneed), 16'h1, "needed in reset");
    reset_i <= 1'b0;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    tick(1);
    chk(rdata, BSR_RESET_VAL, "first read");
    $display("test reset done");
    bsr_mgmt_model_inst.preamble(31);
    tick(2);
    chk(16'(pneed), 16'h1, "31 ones");
    bsr_mgmt_model_inst.preamble(1);
    tick(2);
    chk(16'(pneed), 16'h0, "32 ones");
    $display("test preamble done");
    bsr_mgmt_model_inst.frame(16'($random(seed)));
    bsr_mgmt_model_inst.gap_rise(10);
    tick(60);
    chk(16'(sok), 16'h0, "rise inside gap");
    bsr_mgmt_model_inst.gap_rise(5);
    tick(2);
    chk(16'(sok), 16'h1, "rise after gap");
    bsr_mgmt_model_inst.bad_frame();
    tick(1);
    chk(16'(pneed), 16'h1, "bad frame");
    chk(16'(sok), 16'h0, "bad frame ok");
    bsr_mgmt_model_inst.preamble(32);
    tick(2);
    chk(16'(pneed), 16'h0, "second preamble");
    $display("test gap done");
    traffic(600);
    $display("test traffic done");
    reset_i <= 1'b1;
    tick(2);
    chk(16'(pneed), 16'h1, "mid reset");
    chk(16'(sok), 16'h0, "mid reset ok");
    reset_i <= 1'b0;
    traffic(200);
    tick(3);
    $display("test reset2 done");
    complete_run();
  end
endmodule
`default_nettype wire
